/* File: src/core_exec_pkg.sv */
package core_exec_pkg;

  // ----------------------------------------------------------------
  // Opcode patterns and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] OP_CALL = 4'h9;
  localparam logic [3:0] OP_RETLIT = 4'h8;
  localparam logic [11:0] OP_IDLE = 12'h000;
  localparam logic [11:0] OP_LOAD_OPTION = 12'h002;
  localparam logic [11:0] OP_WDT_CLEAR = 12'h004;
  localparam logic [11:0] OP_ZERO_ACC = 12'h040;
  localparam logic [6:0] OP_STORE_ACC = 7'h01;
  localparam logic [6:0] OP_ZERO_FILE = 7'h03;
  localparam logic [5:0] OP_ROT_RIGHT = 6'h0C;
  localparam logic [5:0] OP_ROT_LEFT = 6'h0D;
  localparam int DEST_BIT = 5;
  localparam int STAT_CARRY = 0;
  localparam int STAT_ZERO = 2;
  localparam int STAT_PD = 3;
  localparam int STAT_TO = 4;
  localparam int STAT_PAGE_LO = 5;
  localparam int OPT_PSA = 3;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [10:0] PC_RESET = 11'h7FF;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic [7:0] STATUS_RESET = 8'h18;
  localparam int LONG_CYCLES = 2;

  typedef enum logic [0:0] {ST_EXEC, ST_SECOND} exec_state_t;

endpackage

/* File: src/core_instruction_subset_exec.sv */
`timescale 1ns/1ns
module core_instruction_subset_exec
  import core_exec_pkg::*;
#(
  parameter int STACK_DEPTH = 2
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Instruction fetch
  input wire logic [11:0] instr,
  output logic [10:0] pc,
  output logic fetch_stall,
  // File register port
  output logic [4:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic [7:0] file_wdata,
  output logic file_we,
  // Core state
  output logic [7:0] acc,
  output logic [7:0] status,
  output logic [7:0] option,
  output logic [10:0] stack_top,
  // Watchdog and prescaler
  output logic wdt_clear,
  output logic prescaler_clear
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  initial
  begin
    // Deeper stacks only cost flip-flops; one entry is the floor
    if (STACK_DEPTH < 1 || STACK_DEPTH > 16)
      $error("STACK_DEPTH out of range");
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  exec_state_t state;
  logic [10:0] stack [STACK_DEPTH];
  logic is_call, is_ret, is_rot_l, is_rot_r, is_rot, is_store, is_zfile;
  logic [7:0] rot_result;
  logic rot_carry;
  logic executing;

  assign executing = (state == ST_EXEC);
  assign is_call = executing && instr[11:8] == OP_CALL;
  assign is_ret = executing && instr[11:8] == OP_RETLIT;
  assign is_rot_l = executing && instr[11:6] == OP_ROT_LEFT;
  assign is_rot_r = executing && instr[11:6] == OP_ROT_RIGHT;
  assign is_rot = is_rot_l || is_rot_r;
  assign is_store = executing && instr[11:5] == OP_STORE_ACC;
  assign is_zfile = executing && instr[11:5] == OP_ZERO_FILE;
  assign file_addr = instr[4:0];
  assign stack_top = stack[0];
  // Second cycle holds fetch while the redirected word is fetched
  assign fetch_stall = !executing;

  // ----------------------------------------------------------------
  // Rotate datapath
  // ----------------------------------------------------------------
  // Rotate through carry, combinational from the file read data
  always_comb
  begin
    rot_result = 8'h00;
    rot_carry = status[STAT_CARRY];
    if (is_rot_l)
    begin
      rot_result = {file_rdata[6:0], status[STAT_CARRY]};
      rot_carry = file_rdata[7];
    end
    else if (is_rot_r)
    begin
      rot_result = {status[STAT_CARRY], file_rdata[7:1]};
      rot_carry = file_rdata[0];
    end
  end

  // ----------------------------------------------------------------
  // File write port
  // ----------------------------------------------------------------
  // File write port; store changes no flag
  always_comb
  begin
    file_we = 1'b0;
    file_wdata = 8'h00;
    if (is_store)
    begin
      file_we = 1'b1;
      file_wdata = acc;
    end
    else if (is_zfile)
    begin
      file_we = 1'b1;
      file_wdata = 8'h00;
    end
    else if (is_rot && instr[DEST_BIT])
    begin
      file_we = 1'b1;
      file_wdata = rot_result;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog strobes
  // ----------------------------------------------------------------
  // Watchdog strobes, one cycle each
  assign wdt_clear = executing && instr == OP_WDT_CLEAR;
  // Shared prescaler only belongs to us when assigned to the watchdog
  assign prescaler_clear = wdt_clear && option[OPT_PSA];

  // ----------------------------------------------------------------
  // Sequencer: two-cycle instructions
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      state <= ST_EXEC;
    else if (is_call || is_ret)
      state <= ST_SECOND;
    else
      state <= ST_EXEC;
  end

  // ----------------------------------------------------------------
  // Program counter and return stack
  // ----------------------------------------------------------------
  // Program counter
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      pc <= PC_RESET;
    else if (is_call)
      pc <= {status[STAT_PAGE_LO+1:STAT_PAGE_LO], 1'b0, instr[7:0]};
    else if (is_ret)
      pc <= stack[0];
    else if (executing)
      pc <= pc + 11'd1;
  end

  // Return stack; push shifts down, pop shifts up
  // Entry 0 is the live return address
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < STACK_DEPTH; i++)
        stack[i] <= 11'h000;
    end
    else if (is_call)
    begin
      stack[0] <= pc + 11'd1;
      for (int i = 1; i < STACK_DEPTH; i++)
        stack[i] <= stack[i-1];
    end
    else if (is_ret)
    begin
      // Bottom entry is repeated: underflow returns to a stale address
      for (int i = 0; i < STACK_DEPTH - 1; i++)
        stack[i] <= stack[i+1];
    end
  end

  // ----------------------------------------------------------------
  // Working registers
  // ----------------------------------------------------------------
  // Accumulator
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      acc <= ACC_RESET;
    else if (is_ret)
      acc <= instr[7:0];
    else if (executing && instr == OP_ZERO_ACC)
      acc <= 8'h00;
    else if (is_rot && !instr[DEST_BIT])
      acc <= rot_result;
  end

  // ----------------------------------------------------------------
  // Status and option
  // ----------------------------------------------------------------
  // Status flags; the clear ops never rotate, so priority cannot clash
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      status <= STATUS_RESET;
    else if (executing && (instr == OP_ZERO_ACC || is_zfile))
      status[STAT_ZERO] <= 1'b1;
    else if (wdt_clear)
    begin
      status[STAT_TO] <= 1'b1;
      status[STAT_PD] <= 1'b1;
    end
    else if (is_rot)
      status[STAT_CARRY] <= rot_carry;
  end

  // Option register
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      option <= OPTION_RESET;
    else if (executing && instr == OP_LOAD_OPTION)
      option <= acc;
  end

endmodule

/* File: verif/core_exec_asserts.sv */
`timescale 1ns/1ns
module core_exec_asserts
  import core_exec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Watched ports
  input wire logic [11:0] instr,
  input wire logic [10:0] pc,
  input wire logic fetch_stall,
  input wire logic [7:0] file_rdata,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  input wire logic [7:0] acc,
  input wire logic [7:0] status,
  input wire logic [7:0] option,
  input wire logic [10:0] stack_top,
  input wire logic wdt_clear,
  input wire logic prescaler_clear
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Decode only counts outside the stall cycle
  wire logic go = !fetch_stall;
  a_call_jump: assert property (go && instr[11:8] == OP_CALL |=> stack_top == 11'($past(pc) + 1)
    && pc == {$past(status[6:5]), 1'b0, $past(instr[7:0])}) else $error("call target");
  a_ret_lit: assert property (go && instr[11:8] == OP_RETLIT |=> acc == $past(instr[7:0])
    && pc == $past(stack_top)) else $error("return");
  a_long_op: assert property (go && instr[11:9] == 3'b100 |=> fetch_stall ##1 !fetch_stall) else $error("len");
  a_zero_file: assert property (go && instr[11:5] == OP_ZERO_FILE |-> file_we && file_wdata == 8'h00
    ##1 status[STAT_ZERO]) else $error("zero file");
  a_wdt_clear: assert property (go && instr == OP_WDT_CLEAR |-> wdt_clear && prescaler_clear == option[OPT_PSA]
    ##1 status[STAT_TO] && status[STAT_PD]) else $error("wdt");
  a_load_opt: assert property (go && instr == OP_LOAD_OPTION |=> option == $past(acc)) else $error("option");
  a_zero_acc: assert property (go && instr == OP_ZERO_ACC |=> acc == 8'h00 && status[STAT_ZERO])
    else $error("zero acc");
  a_rot_right: assert property (go && instr[11:6] == OP_ROT_RIGHT |-> file_we == instr[DEST_BIT]
    && (!file_we || file_wdata == {status[STAT_CARRY], file_rdata[7:1]}) ##1 status[STAT_CARRY] == $past(file_rdata[0]))
    else $error("rotate right");
  a_rot_left: assert property (go && instr[11:6] == OP_ROT_LEFT |-> file_we == instr[DEST_BIT]
    && (!file_we || file_wdata == {file_rdata[6:0], status[STAT_CARRY]}) ##1 status[STAT_CARRY] == $past(file_rdata[7]))
    else $error("rotate");
  a_store_acc: assert property (go && instr[11:5] == OP_STORE_ACC |-> file_we && file_wdata == acc
    ##1 $stable(status)) else $error("store");
endmodule

bind core_instruction_subset_exec core_exec_asserts u_asserts (.*);

/* File: verif/file_reg_model.sv */
`timescale 1ns/1ns
module file_reg_model
(
  // File port
  input wire logic mclk,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic file_we,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [32];
  // Same-cycle read; five address bits reach every cell
  assign file_rdata = mem[file_addr];
  // Distinct start values per cell
  initial
  begin
    foreach (mem[i]) mem[i] = 8'(i * 37 + 5);
  end
  always @(posedge mclk)
  begin
    if (file_we) mem[file_addr] <= file_wdata;
  end
endmodule

/* File: verif/tb_core_instruction_subset_exec.sv */
`timescale 1ns/1ns
module tb_core_instruction_subset_exec;
  import core_exec_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [11:0] instr = 12'h0000;
  logic [10:0] pc, stack_top;
  logic fetch_stall, file_we, wdt_clear, prescaler_clear;
  logic [4:0] file_addr;
  logic [7:0] file_rdata, file_wdata, acc, status, option, e;
  logic [31:0] r = 32'h2b83_b39b;
  int error_cnt = 0, n_checks = 0, cyc = 0;
  core_instruction_subset_exec u_dut (.*);
  file_reg_model u_mem (.*);
  // 10 MHz clock; hang guard far above the run
  initial
  begin
    forever #50 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      error_cnt++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [10:0] seen, input logic [10:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  // Word held through the stall, so the ignored cycle is exercised
  task automatic op(input logic [11:0] i);
    instr = i;
    @(posedge mclk);
    #1;
    if (fetch_stall === 1'b1)
    begin
      @(posedge mclk);
      #1;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    chk("status", status, STATUS_RESET);
    op({OP_RETLIT, 8'h5A});
    chk("acc", acc, 8'h5A);
    chk("pc", pc, 11'h000);
    op({OP_CALL, 8'hC3});
    chk("pc", pc, {STATUS_RESET[6:5], 9'h0C3});
    chk("top", stack_top, 11'h001);
    op(OP_LOAD_OPTION);
    chk("opt", option, 8'h5A);
    instr = OP_WDT_CLEAR;
    #1;
    chk("wdt_psc", {wdt_clear, prescaler_clear}, 2'b11);
    op(OP_WDT_CLEAR);
    chk("to_pd", status[4:3], 2'b11);
    op(OP_ZERO_ACC);
    chk("zacc", {acc, status[STAT_ZERO]}, 9'h001);
    op(OP_LOAD_OPTION);
    instr = OP_WDT_CLEAR;
    #1;
    chk("wdt_only", {wdt_clear, prescaler_clear}, 2'b10);
    op(OP_WDT_CLEAR);
    e = {u_mem.mem[9][6:0], STATUS_RESET[STAT_CARRY]};
    op({OP_ROT_LEFT, 6'h09});
    chk("rl", acc, e);
    op({OP_STORE_ACC, 5'h14});
    chk("st", u_mem.mem[20], e);
    op({OP_ZERO_FILE, 5'h14});
    chk("zf", u_mem.mem[20], 8'h00);
    e = {status[STAT_CARRY], u_mem.mem[9][7:1]};
    op({OP_ROT_RIGHT, 6'h29});
    chk("rr", u_mem.mem[9], e);
    op(OP_IDLE);
    chk("idle", pc, 11'h0CD);
    repeat (400)
    begin
      r = xs(r);
      op(r[11:0]);
    end
    // Mid-run reset: every core register back to its reset value; file memory keeps its contents
    instr = OP_IDLE;
    rst_n = 1'b0;
    @(posedge mclk);
    #1;
    chk("rst_pc", pc, PC_RESET);
    chk("rst_acc", acc, ACC_RESET);
    chk("rst_opt", option, OPTION_RESET);
    chk("rst_stat", status, STATUS_RESET);
    chk("rst_top", stack_top, 11'h000);
    chk("rst_stall", fetch_stall, 1'b0);
    rst_n = 1'b1;
    op(OP_IDLE);
    chk("rst_idle", pc, 11'h000);
    tally_and_finish();
  end
endmodule
